// [core/apt_cnt_if.sv]
// counter state shared by the timer core and its compare channels
// assumes one core driving and any number of channels listening
`timescale 1ns/1ps
`default_nettype none
interface apt_cnt_if;
  logic [7:0] count;
  logic       cnt_tick;
  logic       ovf_evt;
  modport core (output count, output cnt_tick, output ovf_evt);
  modport chan (input count, input cnt_tick, input ovf_evt);
endinterface : apt_cnt_if
`default_nettype wire

// [core/apt_pkg.sv]
// constants, register map and bus states of the auto-reload timer
// assumes a 32-bit AHB-Lite slave decoding the low address byte
package apt_pkg;
  localparam int          CNT_W       = 8;
  localparam int          PSC_W       = 7;
  localparam int          SEL_W       = 3;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CNT     = 8'h04;
  localparam logic [7:0]  OFS_RELOAD  = 8'h08;
  localparam logic [7:0]  OFS_PWMCR   = 8'h0C;
  localparam logic [7:0]  OFS_CAPCSR  = 8'h10;
  localparam logic [7:0]  OFS_CAP0    = 8'h14;
  localparam logic [7:0]  OFS_DUTY0   = 8'h1C;
  localparam logic [7:0]  OFS_STEP    = 8'h04;
  localparam int          B_EXT       = 7;
  localparam int          B_SEL_LO    = 4;
  localparam int          B_EN        = 3;
  localparam int          B_FRC       = 2;
  localparam int          B_OIE       = 1;
  localparam int          B_OVF       = 0;
  localparam int          B_OE_LO     = 4;
  localparam int          B_POL_LO    = 0;
  localparam int          B_EDGE_LO   = 4;
  localparam int          B_CIE_LO    = 2;
  localparam int          B_CF_LO     = 0;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [6:0]  PSC_RST     = 7'h00;
  localparam logic        HRESP_OKAY  = 1'b0;
  typedef enum logic [1:0] {
    APT_BUS_IDLE   = 2'b01,
    APT_BUS_RDWAIT = 2'b10
  } apt_bus_t;
endpackage : apt_pkg

// [core/apt_prescaler.sv]
// seven-bit power-of-two prescaler with eight taps
// assumes tick_in marks one input clock period in the clk_in domain
`timescale 1ns/1ps
`default_nettype none
module apt_prescaler (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      tick_in,
  input  wire logic                      run_in,
  input  wire logic                      clear_in,
  input  wire logic [apt_pkg::SEL_W-1:0] tap_sel_in,
  output logic                           tap_tick_out,
  output logic      [apt_pkg::PSC_W-1:0] psc_out
);
  logic [apt_pkg::PSC_W-1:0] psc;
  logic [apt_pkg::PSC_W-1:0] next_psc;
  logic [apt_pkg::PSC_W:0]   mask8;
  logic [apt_pkg::PSC_W-1:0] mask;

  always_comb begin
    mask8        = (8'h01 << tap_sel_in) - 8'h01;
    mask         = mask8[apt_pkg::PSC_W-1:0];
    tap_tick_out = run_in && tick_in && ((psc & mask) == mask);
    next_psc     = psc;
    if (clear_in) begin
      next_psc = apt_pkg::PSC_RST;
    end else if (run_in && tick_in) begin
      next_psc = psc + 7'h01;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psc <= apt_pkg::PSC_RST;
    end else begin
      psc <= next_psc;
    end
  end

  assign psc_out = psc;
endmodule : apt_prescaler
`default_nettype wire

// [core/apt_pwm_chan.sv]
// one compare channel: hidden compare shadow and pwm level
// assumes count, cnt_tick and ovf_evt come from the timer core
`timescale 1ns/1ps
`default_nettype none
module apt_pwm_chan (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  apt_cnt_if.chan         cnt_if,
  input  wire logic [7:0] duty_cycle_reg_in,
  input  wire logic       output_polarity_bit_in,
  output logic            pwm_level_out
);
  logic [7:0] compare_shadow_value;
  logic [7:0] next_compare_shadow_value;
  logic       lvl;
  logic       next_lvl;
  logic       hit;

  always_comb begin
    hit = cnt_if.cnt_tick && (8'(cnt_if.count + apt_pkg::CNT_ONE) == compare_shadow_value);
    next_compare_shadow_value = compare_shadow_value;
    next_lvl                  = lvl;
    if (cnt_if.ovf_evt) begin
      next_compare_shadow_value = duty_cycle_reg_in;
      next_lvl                  = output_polarity_bit_in;
    end else if (hit) begin
      next_lvl = !output_polarity_bit_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      compare_shadow_value <= apt_pkg::REG_RST;
      lvl                  <= 1'b0;
    end else begin
      compare_shadow_value <= next_compare_shadow_value;
      lvl                  <= next_lvl;
    end
  end

  assign pwm_level_out = lvl;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_shadow_load: assert property (cnt_if.ovf_evt |=> compare_shadow_value == $past(duty_cycle_reg_in)) else $error("shadow not loaded at overflow");
  a_shadow_hold: assert property (!cnt_if.ovf_evt |=> $stable(compare_shadow_value)) else $error("shadow changed outside overflow");
  a_level_at_ovf: assert property (cnt_if.ovf_evt |=> pwm_level_out == $past(output_polarity_bit_in)) else $error("pwm level wrong at overflow");
  a_level_restore: assert property (!cnt_if.ovf_evt && hit |=> pwm_level_out != $past(output_polarity_bit_in)) else $error("pwm level not restored at match");
endmodule : apt_pwm_chan
`default_nettype wire

// [core/apt_timer.sv]
// auto-reload pwm timer core with AHB-Lite register slave
// assumes a single AHB-Lite master, word transfers, inputs synchronous to clk_in
// Summary of operation
// - eight-bit auto-reload up-counter with compare and capture, fed by seven-bit prescaler.
// - counter advances by one on each prescaler output tick.
// - software reads and writes the live counter while it runs.
// - overflow reloads counter from reload value; prescaler unaffected.
// - three-bit tap select divides input clock by two to the power zero..seven.
// - external clock select picks cpu clock when clear, external input when set.
// - with count enable clear, prescaler and counter stay frozen.
// - with count enable set, counter runs at selected divided rate.
// - reset clears counter and prescaler and selects cpu clock.
// - both initialisation paths clear the prescaler.
// - prescaler has no software read or write path.
// - four compare channels, one per pwm output, against own shadow value.
// - compare shadows hidden, loaded from duty registers only at overflow.
// - modes: pwm, time base interrupt, two captures, event counting, external interrupts.
// - pwm, time base and capture run together on one counter clock.
// - timer issues a wake-up request for wait and halt states.
// - overflow drives enabled pwm to polarity; compare match restores opposite level.
// - overflow sets flag, interrupts if enabled, flag cleared by reading control.
// - force reload is write-only, reads zero, reloads counter and clears prescaler.
// - all pwm outputs share frequency counter clock over 256 minus reload.
`timescale 1ns/1ps
`default_nettype none
module apt_timer #(
  parameter int unsigned N_CH  = 4,
  parameter int unsigned N_CAP = 2
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  input  wire logic             ext_clk_in,
  input  wire logic [N_CAP-1:0] capture_in,
  output logic      [N_CH-1:0]  pwm_output_pin_out,
  output logic      [N_CH-1:0]  pwm_oe_out,
  output logic                  irq_out,
  output logic                  wake_req_out
);
  if (N_CH < 1 || N_CH > 4 || N_CAP < 1 || N_CAP > 2) begin : g_chk
    $error("apt_timer supports 1..4 channels and 1..2 captures");
  end

  function automatic logic [7:0] slot(input logic [7:0] base, input int unsigned i);
    slot = base + 8'(i) * apt_pkg::OFS_STEP;
  endfunction : slot

  apt_cnt_if cnt_if ();

  // bus slave state
  apt_pkg::apt_bus_t bus_st;
  apt_pkg::apt_bus_t next_bus_st;
  logic              wr_pend;
  logic              next_wr_pend;
  logic [7:0]        wr_addr;
  logic [7:0]        next_wr_addr;
  logic [7:0]        rd_addr;
  logic [7:0]        next_rd_addr;
  logic [31:0]       hrdata;
  logic [31:0]       next_hrdata;
  logic              hready;
  logic              next_hready;
  logic              take;
  logic [7:0]        rdata;
  logic [7:0]        wdata;
  logic              rd_evt;
  logic              rd_ctrl;
  logic [N_CAP-1:0]  rd_cap;
  logic              wr_ctrl;
  logic              wr_cnt;
  logic              wr_frc;
  logic              wr_reload;
  logic              wr_pwmcr;
  logic              wr_capcsr;
  logic [N_CH-1:0]   wr_duty;

  // timer state
  logic                  ext_clock_select;
  logic                  next_ext_clock_select;
  logic [2:0]            prescale_tap_select;
  logic [2:0]            next_prescale_tap_select;
  logic                  count_enable_bit;
  logic                  next_count_enable_bit;
  logic                  overflow_irq_enable;
  logic                  next_overflow_irq_enable;
  logic                  overflow_flag;
  logic                  next_overflow_flag;
  logic [7:0]            count;
  logic [7:0]            next_count;
  logic [7:0]            reload_value;
  logic [7:0]            next_reload_value;
  logic [N_CH-1:0]       oe;
  logic [N_CH-1:0]       next_oe;
  logic [N_CH-1:0]       pol;
  logic [N_CH-1:0]       next_pol;
  logic [7:0]            duty [N_CH];
  logic [7:0]            next_duty [N_CH];
  logic [N_CAP-1:0]      cap_edge;
  logic [N_CAP-1:0]      next_cap_edge;
  logic [N_CAP-1:0]      cap_ie;
  logic [N_CAP-1:0]      next_cap_ie;
  logic [N_CAP-1:0]      cap_flag;
  logic [N_CAP-1:0]      next_cap_flag;
  logic [7:0]            cap_val [N_CAP];
  logic [7:0]            next_cap_val [N_CAP];
  logic [N_CAP-1:0]      cap_prev;
  logic [N_CAP-1:0]      cap_take;
  logic                  ext_prev;
  logic                  irq;
  logic                  next_irq;
  logic                  in_tick;
  logic                  cnt_tick;
  logic                  ovf_evt;
  logic [N_CH-1:0]       pwm_lvl;
  logic [6:0]            psc;

  // AHB-Lite slave: writes zero-wait, reads one wait state
  always_comb begin
    take         = hsel_in && htrans_in[1] && hready_in;
    next_bus_st  = bus_st;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_rd_addr = rd_addr;
    next_hrdata  = hrdata;
    next_hready  = 1'b1;
    case (bus_st)
      apt_pkg::APT_BUS_IDLE: begin
        if (take && hwrite_in) begin
          next_wr_pend = 1'b1;
          next_wr_addr = haddr_in[7:0];
        end else if (take) begin
          next_rd_addr = haddr_in[7:0];
          next_hready  = 1'b0;
          next_bus_st  = apt_pkg::APT_BUS_RDWAIT;
        end
      end
      apt_pkg::APT_BUS_RDWAIT: begin
        next_hrdata = {24'h000000, rdata};
        next_bus_st = apt_pkg::APT_BUS_IDLE;
      end
      default: begin
        next_bus_st = apt_pkg::APT_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_st  <= apt_pkg::APT_BUS_IDLE;
      wr_pend <= 1'b0;
      wr_addr <= apt_pkg::REG_RST;
      rd_addr <= apt_pkg::REG_RST;
      hrdata  <= 32'h00000000;
      hready  <= 1'b1;
    end else begin
      bus_st  <= next_bus_st;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rd_addr <= next_rd_addr;
      hrdata  <= next_hrdata;
      hready  <= next_hready;
    end
  end

  // address decode, read mux; prescaler is never mapped
  always_comb begin
    wdata     = hwdata_in[7:0];
    rd_evt    = (bus_st == apt_pkg::APT_BUS_RDWAIT);
    rd_ctrl   = rd_evt && (rd_addr == apt_pkg::OFS_CTRL);
    wr_ctrl   = 1'b0;
    wr_cnt    = 1'b0;
    wr_reload = 1'b0;
    wr_pwmcr  = 1'b0;
    wr_capcsr = 1'b0;
    wr_duty   = '0;
    rd_cap    = '0;
    rdata     = apt_pkg::REG_RST;
    if (wr_addr == apt_pkg::OFS_CTRL) begin
      wr_ctrl = wr_pend;
    end else if (wr_addr == apt_pkg::OFS_CNT) begin
      wr_cnt = wr_pend;
    end else if (wr_addr == apt_pkg::OFS_RELOAD) begin
      wr_reload = wr_pend;
    end else if (wr_addr == apt_pkg::OFS_PWMCR) begin
      wr_pwmcr = wr_pend;
    end else if (wr_addr == apt_pkg::OFS_CAPCSR) begin
      wr_capcsr = wr_pend;
    end
    for (int unsigned i = 0; i < N_CH; i++) begin
      if (wr_addr == slot(apt_pkg::OFS_DUTY0, i)) begin
        wr_duty[i] = wr_pend;
      end
      if (rd_addr == slot(apt_pkg::OFS_DUTY0, i)) begin
        rdata = duty[i];
      end
      if (rd_addr == apt_pkg::OFS_PWMCR) begin
        rdata[apt_pkg::B_OE_LO + i]  = oe[i];
        rdata[apt_pkg::B_POL_LO + i] = pol[i];
      end
    end
    for (int unsigned i = 0; i < N_CAP; i++) begin
      if (rd_addr == slot(apt_pkg::OFS_CAP0, i)) begin
        rdata     = cap_val[i];
        rd_cap[i] = rd_evt;
      end
      if (rd_addr == apt_pkg::OFS_CAPCSR) begin
        rdata[apt_pkg::B_EDGE_LO + i] = cap_edge[i];
        rdata[apt_pkg::B_CIE_LO + i]  = cap_ie[i];
        rdata[apt_pkg::B_CF_LO + i]   = cap_flag[i];
      end
    end
    if (rd_addr == apt_pkg::OFS_CTRL) begin
      rdata = {ext_clock_select, prescale_tap_select, count_enable_bit,
               1'b0, overflow_irq_enable, overflow_flag};
    end else if (rd_addr == apt_pkg::OFS_CNT) begin
      rdata = count;
    end else if (rd_addr == apt_pkg::OFS_RELOAD) begin
      rdata = reload_value;
    end
    wr_frc = wr_ctrl && wdata[apt_pkg::B_FRC];
  end

  apt_prescaler u_psc (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .tick_in      (in_tick),
    .run_in       (count_enable_bit),
    .clear_in     (wr_cnt || wr_frc),
    .tap_sel_in   (prescale_tap_select),
    .tap_tick_out (cnt_tick),
    .psc_out      (psc)
  );

  // counter, flags, control and capture next values
  always_comb begin
    in_tick = ext_clock_select ? (ext_clk_in && !ext_prev) : 1'b1;
    ovf_evt = cnt_tick && (count == apt_pkg::CNT_MAX) && !wr_cnt && !wr_frc;
    next_count = count;
    if (wr_cnt) begin
      next_count = wdata;
    end else if (wr_frc || ovf_evt) begin
      next_count = reload_value;
    end else if (cnt_tick) begin
      next_count = 8'(count + apt_pkg::CNT_ONE);
    end
    next_overflow_flag = (overflow_flag && !rd_ctrl) || ovf_evt;
    next_ext_clock_select    = ext_clock_select;
    next_prescale_tap_select = prescale_tap_select;
    next_count_enable_bit    = count_enable_bit;
    next_overflow_irq_enable = overflow_irq_enable;
    if (wr_ctrl) begin
      next_ext_clock_select    = wdata[apt_pkg::B_EXT];
      next_prescale_tap_select = wdata[apt_pkg::B_SEL_LO +: apt_pkg::SEL_W];
      next_count_enable_bit    = wdata[apt_pkg::B_EN];
      next_overflow_irq_enable = wdata[apt_pkg::B_OIE];
    end
    next_reload_value = wr_reload ? wdata : reload_value;
    next_oe           = wr_pwmcr ? wdata[apt_pkg::B_OE_LO +: N_CH] : oe;
    next_pol          = wr_pwmcr ? wdata[apt_pkg::B_POL_LO +: N_CH] : pol;
    next_cap_edge     = wr_capcsr ? wdata[apt_pkg::B_EDGE_LO +: N_CAP] : cap_edge;
    next_cap_ie       = wr_capcsr ? wdata[apt_pkg::B_CIE_LO +: N_CAP] : cap_ie;
    for (int unsigned i = 0; i < N_CH; i++) begin
      next_duty[i] = wr_duty[i] ? wdata : duty[i];
    end
    for (int unsigned i = 0; i < N_CAP; i++) begin
      cap_take[i] = (cap_edge[i] ? (capture_in[i] && !cap_prev[i])
                                 : (!capture_in[i] && cap_prev[i]))
                    && (!cap_flag[i] || rd_cap[i]);
      next_cap_flag[i] = (cap_flag[i] && !rd_cap[i]) || cap_take[i];
      next_cap_val[i]  = cap_take[i] ? count : cap_val[i];
    end
    next_irq = (overflow_flag && overflow_irq_enable) || (|(cap_flag & cap_ie));
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_clock_select    <= 1'b0;
      prescale_tap_select <= 3'h0;
      count_enable_bit    <= 1'b0;
      overflow_irq_enable <= 1'b0;
      overflow_flag       <= 1'b0;
      count               <= apt_pkg::REG_RST;
      reload_value        <= apt_pkg::REG_RST;
      oe                  <= '0;
      pol                 <= '0;
      cap_edge            <= '0;
      cap_ie              <= '0;
      cap_flag            <= '0;
      cap_prev            <= '0;
      ext_prev            <= 1'b0;
      irq                 <= 1'b0;
      for (int unsigned i = 0; i < N_CH; i++) begin
        duty[i] <= apt_pkg::REG_RST;
      end
      for (int unsigned i = 0; i < N_CAP; i++) begin
        cap_val[i] <= apt_pkg::REG_RST;
      end
    end else begin
      ext_clock_select    <= next_ext_clock_select;
      prescale_tap_select <= next_prescale_tap_select;
      count_enable_bit    <= next_count_enable_bit;
      overflow_irq_enable <= next_overflow_irq_enable;
      overflow_flag       <= next_overflow_flag;
      count               <= next_count;
      reload_value        <= next_reload_value;
      oe                  <= next_oe;
      pol                 <= next_pol;
      cap_edge            <= next_cap_edge;
      cap_ie              <= next_cap_ie;
      cap_flag            <= next_cap_flag;
      cap_prev            <= capture_in;
      ext_prev            <= ext_clk_in;
      irq                 <= next_irq;
      duty                <= next_duty;
      cap_val             <= next_cap_val;
    end
  end

  assign cnt_if.count    = count;
  assign cnt_if.cnt_tick = cnt_tick;
  assign cnt_if.ovf_evt  = ovf_evt;

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    apt_pwm_chan u_ch (
      .clk_in                 (clk_in),
      .sys_rst_in             (sys_rst_in),
      .cnt_if                 (cnt_if),
      .duty_cycle_reg_in      (duty[g]),
      .output_polarity_bit_in (pol[g]),
      .pwm_level_out          (pwm_lvl[g])
    );
  end

  assign pwm_output_pin_out = pwm_lvl;
  assign pwm_oe_out         = oe;
  assign irq_out            = irq;
  assign wake_req_out       = irq;
  assign hrdata_out         = hrdata;
  assign hreadyout_out      = hready;
  assign hresp_out          = apt_pkg::HRESP_OKAY;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_reload_on_ovf: assert property (ovf_evt |=> count == $past(reload_value)) else $error("no reload at overflow");
  a_ovf_sets_flag: assert property (ovf_evt |=> overflow_flag) else $error("overflow flag not set");
  a_stop_frozen: assert property (!count_enable_bit && !wr_cnt && !wr_frc |=> $stable(count) && $stable(psc)) else $error("count moved while stopped");
  a_init_clears_psc: assert property (wr_cnt || wr_frc |=> psc == apt_pkg::PSC_RST) else $error("prescaler not cleared on init");
  a_counter_write: assert property (wr_cnt |=> count == $past(wdata)) else $error("counter write lost");
  a_count_step: assert property (cnt_tick && !ovf_evt && !wr_cnt && !wr_frc |=> count == 8'($past(count) + apt_pkg::CNT_ONE)) else $error("counter step wrong");
  a_irq_follows: assert property (overflow_flag && overflow_irq_enable |=> irq_out && wake_req_out) else $error("irq missing");
  a_frc_reads_zero: assert property (rd_ctrl |=> !hrdata_out[apt_pkg::B_FRC] && hreadyout_out) else $error("force reload read not zero");
  a_full_rate: assert property (count_enable_bit && !ext_clock_select && prescale_tap_select == 3'h0 && !wr_cnt && !wr_frc |-> cnt_tick) else $error("undivided clock not ticking");
  c_overflow: cover property (ovf_evt && count_enable_bit);
  c_force_reload: cover property (wr_frc);
  c_capture: cover property (|cap_take);
  c_read_clear: cover property (rd_ctrl && overflow_flag);
endmodule : apt_timer
`default_nettype wire

// [test/apt_ext_model.sv]
// partner: pulse source on the external count clock input
// assumes clk_in is the timer clock; the pulse line idles low between bursts
`timescale 1ns/1ps
`default_nettype none
module apt_ext_model (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [7:0] pulses_in,
  output logic            ext_clk_out
);
  initial begin
    ext_clk_out = 1'b0;
    forever begin
      @(posedge go_in);
      repeat (pulses_in) begin
        repeat (2) @(posedge clk_in);
        ext_clk_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        ext_clk_out <= 1'b0;
      end
    end
  end
endmodule : apt_ext_model
`default_nettype wire

// [test/test_autoreload_pwm_timer_core.sv]
// bench: AHB-Lite tasks and timed scenarios for the auto-reload timer
// assumes one slave whose hreadyout is the bus hready, and the pulse model
`timescale 1ns/1ps
`default_nettype none
module test_autoreload_pwm_timer_core;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rv;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  npul = 8'h00;
  logic [1:0]  cap = 2'h0;
  wire  [31:0] hrdata;
  wire         hready, hresp, ext_clk, irq, wake;
  wire  [3:0]  pwm, oe;
  int          err_count = 0, tests_run = 0, cyc = 0, t0;
  logic [3:0]  exp_pwm [4] = '{4'h4, 4'h6, 4'h2, 4'hA};
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  apt_timer u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ext_clk_in(ext_clk), .capture_in(cap), .pwm_output_pin_out(pwm), .pwm_oe_out(oe),
    .irq_out(irq), .wake_req_out(wake));
  apt_ext_model u_ext (.clk_in(clk_in), .go_in(go), .pulses_in(npul), .ext_clk_out(ext_clk));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] n);
    npul <= n;
    go   <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (50) @(posedge clk_in);
  endtask : pulse
  task automatic at(input int t);
    while (cyc < t) @(posedge clk_in);
  endtask : at
  task automatic complete_run;
    $display("errors %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    rd_chk(apt_pkg::OFS_CTRL, 32'h0);
    rd_chk(apt_pkg::OFS_CNT, 32'h0);
    xfer(apt_pkg::OFS_CNT, 1'b1, 32'h5A);
    repeat (20) @(posedge clk_in);
    rd_chk(apt_pkg::OFS_CNT, 32'h5A);
    xfer(8'h40, 1'b1, 32'hFF);
    rd_chk(8'h40, 32'h0);
    for (int n = 0; n < 8; n++) begin
      xfer(apt_pkg::OFS_CTRL, 1'b1, 32'h08 | (n << 4));
      xfer(apt_pkg::OFS_CNT, 1'b1, 32'h0);
      repeat (5 * (1 << n) + ((1 << n) >> 1) - 1) @(posedge clk_in);
      rd_chk(apt_pkg::OFS_CNT, 32'h5);
    end
    xfer(apt_pkg::OFS_CTRL, 1'b1, 32'h88);
    xfer(apt_pkg::OFS_CNT, 1'b1, 32'h0);
    pulse(8'h07);
    rd_chk(apt_pkg::OFS_CNT, 32'h7);
    xfer(apt_pkg::OFS_CTRL, 1'b1, 32'h80);
    pulse(8'h05);
    rd_chk(apt_pkg::OFS_CNT, 32'h7);
    rd_chk(apt_pkg::OFS_CTRL, 32'h80);
    xfer(apt_pkg::OFS_CAPCSR, 1'b1, 32'h14);
    cap <= 2'h3;
    rd_chk(apt_pkg::OFS_CAPCSR, 32'h15);
    chk(wake, 1'b1);
    rd_chk(apt_pkg::OFS_CAP0, 32'h07);
    xfer(apt_pkg::OFS_CNT, 1'b1, 32'h21);
    cap <= 2'h1;
    rd_chk(apt_pkg::OFS_CAPCSR, 32'h16);
    rd_chk(apt_pkg::OFS_CAP0 + apt_pkg::OFS_STEP, 32'h21);
    xfer(apt_pkg::OFS_PWMCR, 1'b1, 32'hF5);
    for (int k = 0; k < 4; k++) xfer(apt_pkg::OFS_DUTY0 + 8'(4 * k), 1'b1, 32'hF2 + 2 * k);
    xfer(apt_pkg::OFS_RELOAD, 1'b1, 32'hF0);
    xfer(apt_pkg::OFS_CTRL, 1'b1, 32'h7E);
    t0 = cyc;
    rd_chk(apt_pkg::OFS_CTRL, 32'h7A);
    rd_chk(apt_pkg::OFS_CNT, 32'hF0);
    at(t0 + 2112);
    chk(pwm, 4'h5);
    chk(irq, 1'b1);
    chk(wake, 1'b1);
    chk(oe, 4'hF);
    chk(hresp, 1'b0);
    rd_chk(apt_pkg::OFS_CNT, 32'hF0);
    xfer(apt_pkg::OFS_DUTY0, 1'b1, 32'hFE);
    rd_chk(apt_pkg::OFS_CTRL, 32'h7B);
    rd_chk(apt_pkg::OFS_CTRL, 32'h7A);
    chk(irq, 1'b0);
    for (int k = 0; k < 4; k++) begin
      at(t0 + 2368 + 256 * k);
      chk(pwm, exp_pwm[k]);
    end
    at(t0 + 4032);
    chk(pwm, 4'hA);
    at(t0 + 4416);
    chk(pwm, 4'h5);
    complete_run();
  end
endmodule : test_autoreload_pwm_timer_core
`default_nettype wire
